// [design/icp_target.sv]
// device end: two-wire target with volatile and non-volatile spaces
`timescale 1ns/10ps
module icp_target (
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input wire logic ce, // clock enable
   icp_bus_if.target bus, // serial bus
   input wire logic [3:0] ctrl_code, // programmable control code
   output logic wr_strobe, // one-cycle commit pulse
   output logic [10:0] wr_addr, // committed address
   output logic [7:0] wr_data // committed byte
);
   // gray order along idle, control, ack, address, data
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_CTRL = 3'b001, ST_CACK = 3'b011, ST_WADDR = 3'b010,
      ST_DATA = 3'b110, ST_DACK = 3'b111, ST_READ = 3'b101, ST_RACK = 3'b100
   } icp_tst_t;
   typedef struct packed {
      // two-flop synchronisers, then one more stage for edges
      logic [1:0] scl_s, sda_s, scl_m, sda_m;
      icp_tst_t st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic rd;
      logic [2:0] blk;
      logic [10:0] ptr;
      logic sda_oe;
      logic stb;
      logic [10:0] wa;
      logic [7:0] wd;
   } icp_tstate_t;
   icp_tstate_t s_q, s_d;
   // both spaces are 256 bytes, addressed by the low pointer byte
   logic [7:0] vol_mem [256];
   logic [7:0] nvm_mem [256];
   logic [7:0] rd_byte;
   logic [2:0] rd_blk;

   // only the two known spaces answer; other blocks stay silent
   function automatic logic space_ok(input logic [2:0] b);
      space_ok = (b == icp_pkg::BLK_VOLATILE) || (b == icp_pkg::BLK_NVM);
   endfunction

   // word address wraps inside its block; the block bits never carry
   function automatic logic [10:0] next_ptr(input logic [10:0] p);
      next_ptr = {p[10:8], p[7:0] + 8'h01};
   endfunction

   // a read control byte may open another block than the pointer holds
   always_comb begin
      rd_blk = (s_q.st == ST_CACK) ? s_q.blk : s_q.ptr[10:8];
      case (rd_blk)
         icp_pkg::BLK_NVM: rd_byte = nvm_mem[s_q.ptr[7:0]];
         default: rd_byte = vol_mem[s_q.ptr[7:0]];
      endcase
   end
   // every decision uses the second flop; edges compare it with the stage after it
   wire scl = s_q.scl_s[1];
   wire sda = s_q.sda_s[1];
   wire scl_rise = scl & ~s_q.scl_m[0];
   wire scl_fall = ~scl & s_q.scl_m[0];
   wire start = scl & s_q.scl_m[0] & ~sda & s_q.sda_m[0];
   wire stop = scl & s_q.scl_m[0] & sda & ~s_q.sda_m[0];
   // eight bits in and the clock has dropped: acknowledge slot begins
   wire byte_done = scl_fall & (s_q.bitc == 4'd8);

   always_comb begin
      s_d = s_q;
      s_d.scl_s = {s_q.scl_s[0], bus.scl};
      s_d.sda_s = {s_q.sda_s[0], bus.sda};
      s_d.scl_m = {s_q.scl_m[0], scl};
      s_d.sda_m = {s_q.sda_m[0], sda};
      // strobe lasts one cycle
      s_d.stb = 1'b0;
      // a start anywhere, repeated or not, drops a write but keeps the pointer
      if (start) begin
         s_d.st = ST_CTRL;
         s_d.bitc = '0;
         s_d.sda_oe = 1'b0;
      // stop ends any command and releases data
      end else if (stop) begin
         s_d.st = ST_IDLE;
         s_d.sda_oe = 1'b0;
      end else begin
         case (s_q.st)
            ST_CTRL, ST_WADDR, ST_DATA: begin
               // bits are taken on the rising clock, msb first
               if (scl_rise) begin
                  s_d.sh = {s_q.sh[6:0], sda};
                  s_d.bitc = s_q.bitc + 4'h1;
               end
               if (byte_done) begin
                  s_d.bitc = '0;
                  if (s_q.st == ST_CTRL) begin
                     if (s_q.sh[icp_pkg::CODE_MSB:icp_pkg::CODE_LSB] == ctrl_code
                         && space_ok(s_q.sh[icp_pkg::BLK_MSB:icp_pkg::BLK_LSB])) begin
                        s_d.blk = s_q.sh[icp_pkg::BLK_MSB:icp_pkg::BLK_LSB];
                        s_d.rd = s_q.sh[icp_pkg::RW_BIT];
                        s_d.sda_oe = 1'b1;
                        s_d.st = ST_CACK;
                     end else begin
                        // code or block mismatch: stay off the bus
                        s_d.st = ST_IDLE;
                     end
                  end else begin
                     // word address loads the pointer under the block bits
                     if (s_q.st == ST_WADDR) begin
                        s_d.ptr = {s_q.blk, s_q.sh};
                     end else begin
                        // commit at the acknowledge, not at the stop
                        s_d.stb = 1'b1;
                        s_d.wa = s_q.ptr;
                        s_d.wd = s_q.sh;
                        s_d.ptr = next_ptr(s_q.ptr);
                     end
                     s_d.sda_oe = 1'b1;
                     s_d.st = ST_DACK;
                  end
               end
            end

            // after the acknowledge: first read bit or word address
            ST_CACK: begin
               if (scl_fall) begin
                  if (s_q.rd) begin
                     if (s_q.blk != s_q.ptr[10:8]) s_d.ptr = {s_q.blk, s_q.ptr[7:0]};
                     s_d.sh = rd_byte;
                     s_d.sda_oe = ~rd_byte[7];
                     s_d.bitc = 4'd1;
                     s_d.st = ST_READ;
                  end else begin
                     s_d.sda_oe = 1'b0;
                     s_d.st = ST_WADDR;
                  end
               end
            end

            // hold the pull through one full clock pulse
            ST_DACK: begin
               if (scl_fall) begin
                  s_d.sda_oe = 1'b0;
                  s_d.st = ST_DATA;
               end
            end

            // next bit goes out while the clock is low
            ST_READ: begin
               if (scl_fall) begin
                  if (s_q.bitc == 4'd8) begin
                     s_d.sda_oe = 1'b0;
                     s_d.ptr = next_ptr(s_q.ptr);
                     s_d.st = ST_RACK;
                  end else begin
                     s_d.sda_oe = ~s_q.sh[3'(7 - s_q.bitc)];
                     s_d.bitc = s_q.bitc + 4'h1;
                  end
               end
            end

            // master acknowledge continues a sequential read
            ST_RACK: begin
               if (scl_rise) begin
                  if (sda) begin
                     s_d.st = ST_IDLE;
                  end else begin
                     s_d.sh = rd_byte;
                     s_d.st = ST_CACK;
                     s_d.rd = 1'b1;
                     s_d.blk = s_q.ptr[10:8];
                  end
               end
            end

            // idle, the one code not listed above, stays idle until a start
            default: s_d.st = ST_IDLE;
         endcase
      end
   end

   // bus lines reset to their released level so no false edge follows reset
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.scl_s <= 2'h3;
         s_q.sda_s <= 2'h3;
         s_q.scl_m <= 2'h3;
         s_q.sda_m <= 2'h3;
         s_q.st <= ST_IDLE;
         s_q.blk <= icp_pkg::BLK_VOLATILE;
         for (int i = 0; i < 256; i++) vol_mem[i] <= 8'h00;
      end else if (ce) begin
         s_q <= s_d;
         if (s_d.stb && s_q.ptr[10:8] == icp_pkg::BLK_VOLATILE) vol_mem[s_q.ptr[7:0]] <= s_q.sh;
      end
   end
   // non-volatile space keeps contents across reset
   always_ff @(posedge clk) begin
      if (ce && !srst && s_d.stb && s_q.ptr[10:8] == icp_pkg::BLK_NVM) begin
         nvm_mem[s_q.ptr[7:0]] <= s_q.sh;
      end
   end
   assign bus.sda_oe_d = s_q.sda_oe;

   // committed address and data stand until the next commit
   assign wr_strobe = s_q.stb;
   assign wr_addr = s_q.wa;
   assign wr_data = s_q.wd;
endmodule

// [design/icp_pkg.sv]
// shared constants for the two-wire configuration port
package icp_pkg;
   localparam logic [3:0] CTRL_CODE_RST = 4'hF;
   localparam logic [2:0] BLK_VOLATILE = 3'h0;
   localparam logic [2:0] BLK_NVM = 3'h2;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 4;
   localparam int BLK_MSB = 3;
   localparam int BLK_LSB = 1;
   localparam int RW_BIT = 0;
   localparam int PTR_W = 11;
   localparam int SPACE_DEPTH = 256;
   localparam int HALF_BIT_CYC = 313; // 1.25 us half period at 250 MHz
   localparam int FIFO_DEPTH = 8;
endpackage

// [design/icp_bus_if.sv]
// two-wire bus carrier with open-drain resolution
`timescale 1ns/10ps
interface icp_bus_if;
   logic scl_oe_m;
   logic sda_oe_m;
   logic sda_oe_d;
   logic scl;
   logic sda;
   assign scl = ~scl_oe_m;
   assign sda = ~(sda_oe_m | sda_oe_d);
   modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
   modport target (output sda_oe_d, input scl, input sda);
endinterface

// [design/icp_fifo.sv]
// small valid/ready word FIFO
`timescale 1ns/10ps
module icp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input wire logic ce, // clock enable
   input wire logic in_valid, // write request
   output logic in_ready, // not full
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // not empty
   input wire logic out_ready, // read accept
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_q, rp_q;
   wire do_w = in_valid & in_ready;
   wire do_r = out_valid & out_ready;
   assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid = wp_q != rp_q;
   assign out_data = mem[rp_q[AW-1:0]];
   always_ff @(posedge clk) begin
      if (srst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (ce) begin
         if (do_w) begin
            mem[wp_q[AW-1:0]] <= in_data;
            wp_q <= wp_q + 1'b1;
         end
         if (do_r) rp_q <= rp_q + 1'b1;
      end
   end
endmodule

// [design/icp_master.sv]
// far end: two-wire master fed by a command FIFO
`timescale 1ns/10ps
module icp_master #(
   parameter int HALF = icp_pkg::HALF_BIT_CYC
) (
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input wire logic ce, // clock enable
   icp_bus_if.master bus, // serial bus
   input wire logic cmd_valid, // byte to send
   output logic cmd_ready, // fifo has room
   input wire logic [9:0] cmd_data, // {start, stop_after, byte}; read byte if byte=='1 and start=0
   output logic rsp_valid, // one-cycle byte received
   output logic [7:0] rsp_data, // received byte
   output logic rsp_nack // last byte not acknowledged
);
   initial begin
      if (HALF < 2) $error("half period too short");
   end
   typedef enum logic [2:0] {
      M_IDLE = 3'b000, M_START = 3'b001, M_BIT = 3'b011, M_ACK = 3'b010,
      M_STOP = 3'b110
   } icp_mst_t;
   typedef struct packed {
      logic [1:0] sda_s;
      icp_mst_t st;
      logic [15:0] cnt;
      logic ph;
      logic [3:0] bitc;
      logic [9:0] cmd;
      logic [7:0] rx;
      logic scl_oe, sda_oe;
      logic rv, nack;
   } icp_mstate_t;
   icp_mstate_t s_q, s_d;
   logic f_valid, f_ready;
   logic [9:0] f_data;
   icp_fifo #(.WIDTH(10), .DEPTH(icp_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk), .srst(srst), .ce(ce),
      .in_valid(cmd_valid), .in_ready(cmd_ready), .in_data(cmd_data),
      .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data));
   wire tick = s_q.cnt == 16'(HALF - 1);
   wire rd_byte = ~s_q.cmd[9] & (s_q.cmd[7:0] == 8'hFF);
   assign f_ready = (s_q.st == M_IDLE) & f_valid;

   always_comb begin
      s_d = s_q;
      s_d.sda_s = {s_q.sda_s[0], bus.sda};
      s_d.rv = 1'b0;
      s_d.cnt = tick ? '0 : s_q.cnt + 16'h1;
      case (s_q.st)
         M_IDLE: begin
            s_d.cnt = '0;
            if (f_valid) begin
               s_d.cmd = f_data;
               s_d.st = f_data[9] ? M_START : M_BIT;
               s_d.bitc = '0;
               s_d.ph = 1'b0;
            end
         end
         M_START: if (tick) begin
            // clock low first so a target still acknowledging lets data go,
            // then clock high, then data low: also serves as repeated start
            case (s_q.bitc)
               4'h0: begin
                  s_d.scl_oe = 1'b1;
                  s_d.sda_oe = 1'b0;
                  s_d.bitc = 4'h1;
               end
               4'h1: begin
                  s_d.scl_oe = 1'b0;
                  s_d.bitc = 4'h2;
               end
               default: begin
                  s_d.sda_oe = 1'b1;
                  s_d.bitc = '0;
                  s_d.st = M_BIT;
               end
            endcase
         end
         M_BIT: if (tick) begin
            if (!s_q.ph) begin
               s_d.scl_oe = 1'b1;
               s_d.sda_oe = rd_byte ? 1'b0 : ~s_q.cmd[3'(7 - s_q.bitc)];
               s_d.ph = 1'b1;
            end else begin
               s_d.scl_oe = 1'b0;
               s_d.rx = {s_q.rx[6:0], s_q.sda_s[1]};
               s_d.ph = 1'b0;
               s_d.bitc = s_q.bitc + 4'h1;
               if (s_q.bitc == 4'd7) s_d.st = M_ACK;
            end
         end
         M_ACK: if (tick) begin
            if (!s_q.ph) begin
               s_d.scl_oe = 1'b1;
               // read bytes: ack unless this is the last one
               s_d.sda_oe = rd_byte & ~s_q.cmd[8];
               s_d.ph = 1'b1;
            end else begin
               s_d.scl_oe = 1'b0;
               s_d.nack = rd_byte ? 1'b0 : s_q.sda_s[1];
               s_d.rv = rd_byte;
               s_d.ph = 1'b0;
               s_d.st = s_q.cmd[8] ? M_STOP : M_IDLE;
            end
         end
         M_STOP: if (tick) begin
            if (!s_q.ph) begin
               s_d.scl_oe = 1'b1;
               s_d.sda_oe = 1'b1;
               s_d.ph = 1'b1;
            end else if (s_q.scl_oe) begin
               s_d.scl_oe = 1'b0;
            end else begin
               s_d.sda_oe = 1'b0;
               s_d.st = M_IDLE;
            end
         end
         default: s_d.st = M_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.sda_s <= 2'h3;
         s_q.st <= M_IDLE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   // clock is released between commands; a late command only stretches the high time
   assign bus.scl_oe_m = s_q.scl_oe;
   assign bus.sda_oe_m = s_q.sda_oe;
   assign rsp_valid = s_q.rv;
   assign rsp_data = s_q.rx;
   assign rsp_nack = s_q.nack;
endmodule

// [testbench/icp_checker.sv]
// bus-level checker for the target end of the two-wire link
`timescale 1ns/10ps
module icp_checker (
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input wire logic scl_oe_m, // master clock pull
   input wire logic sda_oe_m, // master data pull
   input wire logic sda_oe_d, // target data pull
   input wire logic scl, // resolved clock
   input wire logic sda // resolved data
);
   logic scl_q, sda_q, frame_q;
   logic [4:0] rise_q;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // frame tracker and clock-rise count since the last start
   always_ff @(posedge clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (srst) begin
         frame_q <= 1'b0;
         rise_q <= 5'h0;
      end else if (scl && scl_q && sda_q && !sda) begin
         frame_q <= 1'b1;
         rise_q <= 5'h0;
      end else if (scl && scl_q && !sda_q && sda) begin
         frame_q <= 1'b0;
      end else if (scl && !scl_q && rise_q != 5'h1F) begin
         rise_q <= rise_q + 5'h1;
      end
   end
   sequence s_ack_held;
      sda_oe_d [*4];
   endsequence
   a_idle_no_drive: assert property (!frame_q |-> !sda_oe_d)
      else $error("target drives outside a frame");
   a_ctrl_ack_slot: assert property ($rose(sda_oe_d) && rise_q < 5'h9 |-> rise_q == 5'h8)
      else $error("control acknowledge in wrong bit slot");
   a_drive_scl_low: assert property ($rose(sda_oe_d) |-> !scl)
      else $error("target pulls data while clock high");
   a_release_scl_low: assert property ($fell(sda_oe_d) |-> !scl)
      else $error("target releases data while clock high");
   a_stable_scl_high: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
      else $error("target data moves during clock high");
   a_ack_holds: assert property ($rose(sda_oe_d) |-> s_ack_held)
      else $error("target pull too short");
   a_drive_bounded: assert property ($rose(sda_oe_d) |-> ##[1:200] !sda_oe_d)
      else $error("target pull never released");
   a_reset_quiet: assert property ($fell(srst) |-> !sda_oe_d)
      else $error("target drives right after reset");
endmodule

// [testbench/tb.sv]
// self-checking bench: master and target joined over the bus
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   $display("wrong value %s exp %0h got %0h", nm, e, g); miscompares++; end end
module tb;
   logic clk, srst, cmd_valid, cmd_ready, rsp_valid, rsp_nack, wr_strobe, strobe_q;
   logic [9:0] cmd_data;
   logic [7:0] rsp_data, wr_data;
   logic [10:0] wr_addr;
   logic [3:0] ctrl_code;
   logic [18:0] commits[$];
   int miscompares, checks_done;
   icp_bus_if bus ();
   // short half period keeps the run brief, with margin over the target minimum
   icp_master #(.HALF(6)) u_icp_master (.clk(clk), .srst(srst), .ce(1'b1), .bus(bus.master),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   icp_target u_icp_target (.clk(clk), .srst(srst), .ce(1'b1), .bus(bus.target),
      .ctrl_code(ctrl_code), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
   icp_checker u_icp_checker (.clk(clk), .srst(srst), .scl_oe_m(bus.scl_oe_m),
      .sda_oe_m(bus.sda_oe_m), .sda_oe_d(bus.sda_oe_d), .scl(bus.scl), .sda(bus.sda));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // address and data stand until the next commit, so read them a cycle late
   always @(posedge clk) begin
      strobe_q <= wr_strobe;
      if (strobe_q === 1'b1) commits.push_back({wr_addr, wr_data});
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // up to five commands, first one in the top bits
   task automatic xfer(input int n, input logic [49:0] c);
      @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         cmd_valid <= 1'b1;
         cmd_data <= c[10*i +: 10];
         do @(posedge clk); while (cmd_ready !== 1'b1);
      end
      cmd_valid <= 1'b0;
   endtask
   task automatic get_commit(input logic [10:0] a, input logic [7:0] d);
      logic [18:0] got;
      repeat (3000) if (commits.size() == 0) @(posedge clk);
      got = commits.size() ? commits.pop_front() : 19'hX;
      `CHK("commit", {a, d}, got)
   endtask
   task automatic get_rsp(input logic [7:0] d);
      repeat (3000) begin
         @(posedge clk);
         if (rsp_valid === 1'b1) break;
      end
      `CHK("rsp_valid", 1'b1, rsp_valid)
      @(posedge clk);
      `CHK("rsp_data", d, rsp_data)
   endtask
   task automatic t_write;
      xfer(3, {10'h2F0, 10'h012, 10'h15A});
      xfer(3, {10'h2F0, 10'h013, 10'h1C3});
      get_commit(11'h012, 8'h5A);
      get_commit(11'h013, 8'hC3);
      repeat (60) @(posedge clk);
      `CHK("nack", 1'b0, rsp_nack)
      $display("t_write done");
   endtask
   task automatic t_page;
      xfer(5, {10'h2F4, 10'h0FE, 10'h011, 10'h022, 10'h133});
      get_commit(11'h2FE, 8'h11);
      get_commit(11'h2FF, 8'h22);
      get_commit(11'h200, 8'h33);
      $display("t_page done");
   endtask
   task automatic t_read(input logic [7:0] d, input logic [7:0] d_next);
      xfer(4, {10'h2F0, 10'h012, 10'h2F1, 10'h1FF});
      get_rsp(d);
      xfer(2, {10'h2F1, 10'h1FF});
      get_rsp(d_next);
      `CHK("aborted", 0, commits.size())
      $display("t_read done");
   endtask
   task automatic t_refuse;
      ctrl_code <= 4'hA;
      xfer(2, {10'h2F0, 10'h112});
      repeat (800) @(posedge clk);
      `CHK("nack code", 1'b1, rsp_nack)
      xfer(3, {10'h2A0, 10'h020, 10'h177});
      get_commit(11'h020, 8'h77);
      ctrl_code <= 4'hF;
      xfer(2, {10'h2F2, 10'h112});
      repeat (800) @(posedge clk);
      `CHK("nack block", 1'b1, rsp_nack)
      $display("t_refuse done");
   endtask
   task automatic t_reset;
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_read(8'h00, 8'h00);
      $display("t_reset done");
   endtask
   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_data = 10'h000;
      ctrl_code = 4'hF;
      strobe_q = 1'b0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_write;
      t_page;
      t_read(8'h5A, 8'hC3);
      t_refuse;
      t_reset;
      tally_and_finish;
   end
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      tally_and_finish;
   end
endmodule
